// ==== rtl/dma_channel_count_and_address.sv ====
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
`include "dma_channel_defines.svh"

//
// Behaviour
// - Each channel keeps a 16-bit count of transfers left, 0 to 65535, upper bits read zero.
// - Software writes to the count take effect only while the channel is off.
// - While the channel is on the count is read-only and reads show the transfers left.
// - Each completed single transfer of a channel lowers its count by one.
// - A channel without auto-reload ends its block with the count at zero.
// - A channel in auto-reload mode reloads the last programmed count at the block's end.
// - A channel whose count is zero moves no data, whether on or off.
// - Each channel keeps a 32-bit peripheral base address that ignores writes while on.
// - Each channel keeps a 32-bit memory base address that ignores writes while on.
// - A 16-bit peripheral word size clears bit 0 of the peripheral address.
// - A 32-bit peripheral word size clears bits 1:0 of the peripheral address.
// - A 16-bit memory word size clears bit 0 of the memory address.
// - A 32-bit memory word size clears bits 1:0 of the memory address.
// - Peripheral word size codes are 00 8-bit, 01 16-bit, 10 32-bit, 11 reserved.
// - Memory word size codes are 00 8-bit, 01 16-bit, 10 32-bit, 11 reserved.
//
module dma_channel_count_and_address
   import dma_channel_pkg::*;
(
   input  wire logic                  pclk,     // System clock, 125 MHz.
   input  wire logic                  presetn,  // Asynchronous reset, active low.
   input  wire logic                  psel,     // APB select.
   input  wire logic                  penable,  // APB access phase.
   input  wire logic                  pwrite,   // APB direction, high for write.
   input  wire logic [31:0]           paddr,    // APB byte address.
   input  wire logic [31:0]           pwdata,   // APB write data.
   output logic                       pready,   // APB ready, always high.
   output logic [31:0]                prdata,   // APB read data, registered.
   output logic                       pslverr,  // APB error on unmapped address.
   input  wire logic [`CH_COUNT-1:0]  xfer_req, // Peripheral transfer requests, level.
   output logic                       rd_valid, // Source read request.
   input  wire logic                  rd_ready, // Source read done, data valid.
   output logic [31:0]                rd_addr,  // Source address, aligned.
   output logic [1:0]                 rd_size,  // Source word size code.
   input  wire logic [31:0]           rd_data,  // Source read data.
   output logic                       wr_valid, // Destination write request.
   input  wire logic                  wr_ready, // Destination write done.
   output logic [31:0]                wr_addr,  // Destination address, aligned.
   output logic [1:0]                 wr_size,  // Destination word size code.
   output logic [31:0]                wr_data   // Destination write data.
);

   // ****************************************************************
   // State and helpers.
   // ****************************************************************
   typedef struct packed {
      logic [`CH_COUNT-1:0][`CFG_WIDTH-1:0] cfg;
      logic [`CH_COUNT-1:0][15:0]           count;
      logic [`CH_COUNT-1:0][15:0]           reload;
      logic [`CH_COUNT-1:0][31:0]           paddr;
      logic [`CH_COUNT-1:0][31:0]           maddr;
      logic [`CH_COUNT-1:0]                 done;
      engine_e                              eng;
      logic [2:0]                           ch;
      logic [1:0]                           inflight;
      logic [31:0]                          rd_addr;
      logic [1:0]                           rd_size;
      logic [31:0]                          dst_addr;
      logic [1:0]                           dst_size;
      logic [31:0]                          prdata;
      logic                                 pslverr;
   } dma_state_s;

   dma_state_s                state_reg;
   dma_state_s                state_next;
   reg_hit_s                  dec;
   logic                      apb_setup;
   logic                      apb_wr;
   logic                      buf_in_valid;
   logic                      buf_in_ready;
   logic [`ENTRY_WIDTH-1:0]   buf_in_data;
   logic [`ENTRY_WIDTH-1:0]   buf_out_data;
   logic                      wr_fire;
   logic [2:0]                wr_ch;

   // Forces an address onto the boundary of its word size.
   function automatic logic [31:0] align_addr(input logic [31:0] a, input logic [1:0] size);
      logic [31:0] r;
      r = a;
      if (size == `SIZE_16) begin
         r[0] = 1'b0;
      end else if (size == `SIZE_32) begin
         r[1:0] = 2'h0;
      end
      return r;
   endfunction

   // Maps a byte address onto a channel and one of its four registers. Each
   // channel's window is five words long and its fifth word is a reserved
   // gap; that gap must not alias the configuration register.
   function automatic reg_hit_s reg_decode(input logic [31:0] a);
      reg_hit_s    r;
      logic [31:0] base;
      r = '0;
      for (int i = 0; i < `CH_COUNT; i++) begin
         base = `CFG_OFFSET + (32'(i) * `CH_STRIDE);
         if (a >= base && a <= base + (`MADDR_OFFSET - `CFG_OFFSET) && a[1:0] == 2'h0) begin
            r.hit = 1'b1;
            r.ch  = 3'(i);
            r.sel = reg_sel_e'(2'((a - base) >> 2));
         end
      end
      return r;
   endfunction

   // APB decode shared by reads and writes. Zero wait states throughout.
   assign dec       = reg_decode(paddr);
   assign apb_setup = psel && !penable;
   assign apb_wr    = psel && penable && pwrite && dec.hit;
   assign pready    = 1'b1;
   assign prdata    = state_reg.prdata;
   assign pslverr   = state_reg.pslverr;

   // Engine outputs; the write side is the buffer's head entry.
   assign rd_valid     = (state_reg.eng == eng_read);
   assign rd_addr      = state_reg.rd_addr;
   assign rd_size      = state_reg.rd_size;
   assign buf_in_valid = rd_valid && rd_ready;
   assign buf_in_data  = {state_reg.ch, state_reg.dst_addr, state_reg.dst_size, rd_data};
   assign wr_ch        = buf_out_data[68:66];
   assign wr_addr      = buf_out_data[65:34];
   assign wr_size      = buf_out_data[33:32];
   assign wr_data      = buf_out_data[31:0];
   assign wr_fire      = wr_valid && wr_ready;

   // ****************************************************************
   // Data buffer between source reads and destination writes.
   // ****************************************************************
   dma_pair_buffer u_pair_buffer (
      .pclk      (pclk),
      .presetn   (presetn),
      .in_valid  (buf_in_valid),
      .in_ready  (buf_in_ready),
      .in_data   (buf_in_data),
      .out_valid (wr_valid),
      .out_ready (wr_ready),
      .out_data  (buf_out_data)
   );

   // ****************************************************************
   // Next-state logic: registers, counters and the read engine.
   // ****************************************************************
   always_comb begin
      logic       found;
      logic [2:0] pick;
      logic       src_mem;
      logic [1:0] psz;
      logic [1:0] msz;
      logic [1:0] infl;
      found      = 1'b0;
      pick       = 3'h0;
      src_mem    = 1'b0;
      psz        = `SIZE_8;
      msz        = `SIZE_8;
      infl       = state_reg.inflight;
      state_next = state_reg;

      // Read data is caught in the setup phase so it comes from a register.
      if (apb_setup) begin
         state_next.prdata  = `REG_RESET;
         state_next.pslverr = !dec.hit;
         if (dec.hit && !pwrite) begin
            unique case (dec.sel)
               sel_cfg:   state_next.prdata = {17'h0, state_reg.cfg[dec.ch]};
               sel_count: state_next.prdata = {16'h0, state_reg.count[dec.ch]};
               sel_paddr: state_next.prdata = state_reg.paddr[dec.ch];
               sel_maddr: state_next.prdata = state_reg.maddr[dec.ch];
            endcase
         end
      end

      // A completed write is one finished transfer of its channel.
      if (wr_fire) begin
         infl = infl - 2'h1;
         if (state_reg.count[wr_ch] == 16'h0001) begin
            if (state_reg.cfg[wr_ch][`CFG_RELOAD_BIT]) begin
               state_next.count[wr_ch] = state_reg.reload[wr_ch];
            end else begin
               state_next.count[wr_ch] = 16'h0000;
               state_next.done[wr_ch]  = 1'b1;
            end
         end else if (state_reg.count[wr_ch] != 16'h0000) begin
            state_next.count[wr_ch] = state_reg.count[wr_ch] - 16'h0001;
         end
      end

      // Software writes; count and addresses are locked while the channel is on.
      if (apb_wr) begin
         unique case (dec.sel)
            sel_cfg: begin
               state_next.cfg[dec.ch] = pwdata[`CFG_WIDTH-1:0] & `CFG_MASK;
            end
            sel_count: begin
               if (!state_reg.cfg[dec.ch][`CFG_ON_BIT]) begin
                  state_next.count[dec.ch]  = pwdata[15:0];
                  state_next.reload[dec.ch] = pwdata[15:0];
               end
            end
            sel_paddr: begin
               if (!state_reg.cfg[dec.ch][`CFG_ON_BIT]) begin
                  state_next.paddr[dec.ch] = pwdata;
               end
            end
            sel_maddr: begin
               if (!state_reg.cfg[dec.ch][`CFG_ON_BIT]) begin
                  state_next.maddr[dec.ch] = pwdata;
               end
            end
         endcase
      end

      // Turning a channel off re-arms it after a finished block.
      for (int i = 0; i < `CH_COUNT; i++) begin
         if (!state_next.cfg[i][`CFG_ON_BIT]) begin
            state_next.done[i] = 1'b0;
         end
      end

      // Pick the lowest eligible channel; words already read count against it,
      // and another channel waits until the buffer has drained.
      for (int i = `CH_COUNT - 1; i >= 0; i--) begin
         if (state_reg.cfg[i][`CFG_ON_BIT] && !state_reg.done[i]
             && (xfer_req[i] || state_reg.cfg[i][`CFG_M2M_BIT])
             && ((state_reg.inflight == 2'h0 && state_reg.count[i] != 16'h0000)
                 || (3'(i) == state_reg.ch
                     && state_reg.count[i] > {14'h0, state_reg.inflight}))) begin
            found = 1'b1;
            pick  = 3'(i);
         end
      end

      // Read engine: one source read at a time, started only with buffer room.
      unique case (state_reg.eng)
         eng_idle: begin
            if (found && buf_in_ready) begin
               src_mem = state_reg.cfg[pick][`CFG_DIR_BIT];
               psz     = state_reg.cfg[pick][`CFG_PSIZE_LSB +: 2];
               msz     = state_reg.cfg[pick][`CFG_MEMORY_WORD_SIZE_LSB +: 2];
               state_next.ch  = pick;
               state_next.eng = eng_read;
               if (src_mem) begin
                  state_next.rd_addr  = align_addr(state_reg.maddr[pick], msz);
                  state_next.rd_size  = msz;
                  state_next.dst_addr = align_addr(state_reg.paddr[pick], psz);
                  state_next.dst_size = psz;
               end else begin
                  state_next.rd_addr  = align_addr(state_reg.paddr[pick], psz);
                  state_next.rd_size  = psz;
                  state_next.dst_addr = align_addr(state_reg.maddr[pick], msz);
                  state_next.dst_size = msz;
               end
            end
         end
         eng_read: begin
            if (rd_ready) begin
               infl           = infl + 2'h1;
               state_next.eng = eng_idle;
            end
         end
      endcase
      state_next.inflight = infl;
   end

   // State register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg     <= '0;
         state_reg.eng <= eng_idle;
      end else begin
         state_reg <= state_next;
      end
   end

   // ****************************************************************
   // Checks.
   // ****************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_count_write_off: assert property (
      apb_wr && dec.sel == sel_count && !state_reg.cfg[dec.ch][`CFG_ON_BIT]
      |=> state_reg.count[$past(dec.ch)] == $past(pwdata[15:0]))
      else $error("count write while off was not taken");

   chk_count_write_on: assert property (
      apb_wr && dec.sel == sel_count && state_reg.cfg[dec.ch][`CFG_ON_BIT]
      && !(wr_fire && wr_ch == dec.ch)
      |=> state_reg.count[$past(dec.ch)] == $past(state_reg.count[dec.ch]))
      else $error("count changed by a write while on");

   chk_count_readback: assert property (
      apb_setup && !pwrite && dec.hit && dec.sel == sel_count
      |=> prdata == {16'h0, $past(state_reg.count[dec.ch])})
      else $error("count read did not show the transfers left");

   chk_count_step: assert property (
      wr_fire && state_reg.count[wr_ch] > 16'h0001 && !apb_wr
      |=> state_reg.count[$past(wr_ch)] == $past(state_reg.count[wr_ch]) - 16'h0001)
      else $error("count did not step down by one");

   chk_block_end: assert property (
      wr_fire && state_reg.count[wr_ch] == 16'h0001
      && !state_reg.cfg[wr_ch][`CFG_RELOAD_BIT] && !apb_wr
      |=> state_reg.count[$past(wr_ch)] == 16'h0000 && state_reg.done[$past(wr_ch)])
      else $error("finished block did not leave zero");

   chk_reload_value: assert property (
      wr_fire && state_reg.count[wr_ch] == 16'h0001
      && state_reg.cfg[wr_ch][`CFG_RELOAD_BIT] && !apb_wr
      |=> state_reg.count[$past(wr_ch)] == $past(state_reg.reload[wr_ch]))
      else $error("auto-reload did not restore the count");

   chk_zero_no_read: assert property (
      $rose(rd_valid) |-> state_reg.count[state_reg.ch] != 16'h0000)
      else $error("read started on a channel with zero count");

   chk_done_idle: assert property (
      state_reg.eng == eng_idle && state_next.eng == eng_read
      |-> !state_reg.done[state_next.ch] && state_reg.cfg[state_next.ch][`CFG_ON_BIT])
      else $error("finished or disabled channel started a read");

   chk_rd_align: assert property (
      rd_valid |-> (rd_size != `SIZE_16 || !rd_addr[0])
                   && (rd_size != `SIZE_32 || rd_addr[1:0] == 2'h0))
      else $error("source address not aligned to its size");

   chk_wr_align: assert property (
      wr_valid |-> (wr_size != `SIZE_16 || !wr_addr[0])
                   && (wr_size != `SIZE_32 || wr_addr[1:0] == 2'h0))
      else $error("destination address not aligned to its size");

   chk_base_locked: assert property (
      apb_wr && dec.sel inside {sel_paddr, sel_maddr}
      && state_reg.cfg[dec.ch][`CFG_ON_BIT]
      |=> $stable(state_reg.paddr) && $stable(state_reg.maddr))
      else $error("base address written while channel on");

endmodule // dma_channel_count_and_address

// ==== rtl/dma_channel_defines.svh ====
`ifndef DMA_CHANNEL_DEFINES_SVH
`define DMA_CHANNEL_DEFINES_SVH

// ****************************************************************
// Channel count and register map.
// ****************************************************************
`define CH_COUNT       5
`define CH_STRIDE      32'h0000_0014
`define CFG_OFFSET     32'h0000_0008
`define COUNT_OFFSET   32'h0000_000c
`define PADDR_OFFSET   32'h0000_0010
`define MADDR_OFFSET   32'h0000_0014
`define REG_RESET      32'h0000_0000

// ****************************************************************
// Configuration register fields.
// ****************************************************************
`define CFG_WIDTH      15
`define CFG_ON_BIT     0
`define CFG_DIR_BIT    4
`define CFG_RELOAD_BIT 5
`define CFG_PSIZE_LSB  8
`define CFG_MEMORY_WORD_SIZE_LSB  10
`define CFG_M2M_BIT    14
`define CFG_MASK       15'h7fff

// ****************************************************************
// Word size codes and buffer layout.
// ****************************************************************
`define SIZE_8         2'h0
`define SIZE_16        2'h1
`define SIZE_32        2'h2
`define ENTRY_WIDTH    69

`endif

// ==== rtl/dma_channel_pkg.sv ====
package dma_channel_pkg;

   // Transfer engine states, one-hot.
   typedef enum logic [1:0] {
      eng_idle = 2'b01,
      eng_read = 2'b10
   } engine_e;

   // Register selector inside one channel's window.
   typedef enum logic [1:0] {
      sel_cfg   = 2'h0,
      sel_count = 2'h1,
      sel_paddr = 2'h2,
      sel_maddr = 2'h3
   } reg_sel_e;

   // Result of an APB address decode.
   typedef struct packed {
      logic     hit;
      logic [2:0] ch;
      reg_sel_e sel;
   } reg_hit_s;

endpackage

// ==== rtl/dma_pair_buffer.sv ====
`timescale 1ns/10ps
`include "dma_channel_defines.svh"

// Two-entry buffer; the oldest word always sits in the head register.
module dma_pair_buffer
   import dma_channel_pkg::*;
(
   input  wire logic                      pclk,      // System clock.
   input  wire logic                      presetn,   // Asynchronous reset, active low.
   input  wire logic                      in_valid,  // Filling side offers a word.
   output logic                           in_ready,  // Room for a word.
   input  wire logic [`ENTRY_WIDTH-1:0]   in_data,   // Word offered.
   output logic                           out_valid, // Head word available.
   input  wire logic                      out_ready, // Draining side takes the head.
   output logic [`ENTRY_WIDTH-1:0]        out_data   // Head word, from a register.
);

   typedef struct packed {
      logic [`ENTRY_WIDTH-1:0] head;
      logic [`ENTRY_WIDTH-1:0] tail;
      logic [1:0]              fill;
   } pair_s;

   pair_s buf_reg;
   pair_s buf_next;
   logic  push;
   logic  pop;

   // Handshakes. A full buffer refuses a push even when popped, which keeps
   // the ready path free of the drain side at the cost of one bubble.
   assign in_ready  = (buf_reg.fill != 2'h2);
   assign out_valid = (buf_reg.fill != 2'h0);
   assign out_data  = buf_reg.head;
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Next-state of the two entries and the fill level.
   always_comb begin
      buf_next = buf_reg;
      unique case ({push, pop})
         2'b10: begin
            if (buf_reg.fill == 2'h0) begin
               buf_next.head = in_data;
            end else begin
               buf_next.tail = in_data;
            end
            buf_next.fill = buf_reg.fill + 2'h1;
         end
         2'b01: begin
            buf_next.head = buf_reg.tail;
            buf_next.fill = buf_reg.fill - 2'h1;
         end
         2'b11: begin
            buf_next.head = in_data;
         end
         default: begin
            buf_next = buf_reg;
         end
      endcase
   end

   // State register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         buf_reg <= '0;
      end else begin
         buf_reg <= buf_next;
      end
   end

endmodule // dma_pair_buffer

// ==== verif/dma_far_side_model.sv ====
`timescale 1ns/10ps

// Far side: answers source reads and destination writes after a set wait.
module dma_far_side_model (
   input  wire logic        pclk,     // System clock.
   input  wire logic        presetn,  // Reset, active low.
   input  wire logic [3:0]  rdel,     // Wait cycles before a read answer.
   input  wire logic [3:0]  wdel,     // Wait cycles before a write answer.
   input  wire logic        rd_valid, // Read request.
   output logic             rd_ready, // Read answer, one cycle.
   output logic [31:0]      rd_data,  // Read data.
   input  wire logic [31:0] rd_addr,  // Read address.
   input  wire logic        wr_valid, // Write request.
   output logic             wr_ready, // Write answer, one cycle.
   input  wire logic [31:0] wr_addr,  // Write address.
   input  wire logic [31:0] wr_data,  // Write data.
   input  wire logic [1:0]  wr_size,  // Write word size code.
   output int               n_wr,     // Writes taken.
   output logic [31:0]      last_ra,  // Last read address.
   output logic [31:0]      last_wa,  // Last write address.
   output logic [31:0]      last_wd,  // Last write data.
   output logic [1:0]       last_ws   // Last write size code.
);
   int rw, ww, nr;

   // Each answer is a one-cycle pulse; the data line toggles between
   // answers so that a stale word is never mistaken for a fresh one.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_ready <= 1'b0;
         wr_ready <= 1'b0;
         rd_data  <= 32'h0;
         rw       <= 0;
         ww       <= 0;
         nr       <= 0;
         n_wr     <= 0;
         last_ra  <= 32'h0;
         last_wa  <= 32'h0;
         last_wd  <= 32'h0;
         last_ws  <= 2'h0;
      end else begin
         rd_ready <= 1'b0;
         wr_ready <= 1'b0;
         rd_data  <= ~rd_data;
         if (rd_valid && !rd_ready) begin
            if (rw >= int'(rdel)) begin
               rd_ready <= 1'b1;
               rd_data  <= 32'h5a00_0000 + nr;
               nr       <= nr + 1;
               last_ra  <= rd_addr;
               rw       <= 0;
            end else rw <= rw + 1;
         end
         if (wr_valid && !wr_ready) begin
            if (ww >= int'(wdel)) begin
               wr_ready <= 1'b1;
               ww       <= 0;
            end else ww <= ww + 1;
         end
         if (wr_valid && wr_ready) begin
            n_wr    <= n_wr + 1;
            last_wa <= wr_addr;
            last_wd <= wr_data;
            last_ws <= wr_size;
         end
      end
   end
endmodule // dma_far_side_model

// ==== verif/tb_top.sv ====
`timescale 1ns/10ps
`include "dma_channel_defines.svh"

module tb_top;
   import dma_channel_pkg::*;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic [31:0] paddr = 0, pwdata = 0, prdata, rd_addr, rd_data, wr_addr, wr_data;
   logic        rd_valid, rd_ready, wr_valid, wr_ready, e;
   logic [4:0]  xfer_req = 0;
   logic [1:0]  rd_size, wr_size, last_ws;
   logic [3:0]  rdel = 0, wdel = 0;
   logic [31:0] last_ra, last_wa, last_wd, q;
   int          n_wr, errors = 0, cmp_count = 0, b;

   // ****************************************************************
   // Clock, design and far side.
   // ****************************************************************
   always #4 pclk = ~pclk;

   dma_channel_count_and_address i_dma_channel_count_and_address (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .xfer_req(xfer_req), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_addr(rd_addr),
      .rd_size(rd_size), .rd_data(rd_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
      .wr_addr(wr_addr), .wr_size(wr_size), .wr_data(wr_data));

   dma_far_side_model i_dma_far_side_model (.pclk(pclk), .presetn(presetn), .rdel(rdel),
      .wdel(wdel), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
      .rd_addr(rd_addr), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
      .wr_data(wr_data), .wr_size(wr_size), .n_wr(n_wr), .last_ra(last_ra),
      .last_wa(last_wa), .last_wd(last_wd), .last_ws(last_ws));

   // ****************************************************************
   // Shared tasks.
   // ****************************************************************
   task automatic end_sim;
      if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; the request is held until pready is seen high.
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         errors++;
         $display("Error at %0t: no bus answer", $time);
         end_sim;
      end
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(q, exp);
   endtask

   // Waits for the far side to have taken n writes, within a bound.
   task automatic wait_wr(input int n);
      int i;
      for (i = 0; i < 600 && n_wr < n; i++) @(posedge pclk);
      if (n_wr < n) begin
         errors++;
         $display("Error at %0t: writes did not arrive", $time);
         end_sim;
      end
      chk(last_wd, 32'h5a00_0000 + 32'(n_wr - 1));
   endtask

   function automatic logic [31:0] ra(input int ch, input int off);
      return `CFG_OFFSET + `CH_STRIDE * 32'(ch - 1) + 32'(off);
   endfunction

   function automatic logic [31:0] cfg(input int on, input int rl, input int ps, input int ms);
      return (32'(ms) << `CFG_MEMORY_WORD_SIZE_LSB) | (32'(ps) << `CFG_PSIZE_LSB) |
             (32'(rl) << `CFG_RELOAD_BIT) | 32'(on);
   endfunction

   // ****************************************************************
   // Main sequence.
   // ****************************************************************
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rdc(ra(1, 4), 32'h0);
      rdc(ra(1, 8), 32'h0);
      rdc(ra(1, 12), 32'h0);
      apb(1'b0, 32'h0000_0100, 32'h0);
      chk({31'h0, e}, 32'h1);
      // The reserved fifth word of a channel's window is unmapped as well.
      apb(1'b0, ra(1, 16), 32'h0);
      chk({31'h0, e}, 32'h1);
      // Slow far side so the count can be read between transfers.
      rdel <= 4'hf;
      wdel <= 4'hf;
      apb(1'b1, ra(1, 4), 32'h0001_0003);
      rdc(ra(1, 4), 32'h3);
      apb(1'b1, ra(1, 8), 32'h1233);
      apb(1'b1, ra(1, 12), 32'h2007);
      apb(1'b1, ra(1, 0), cfg(1, 0, 1, 2));
      apb(1'b1, ra(1, 4), 32'h5);
      apb(1'b1, ra(1, 8), 32'h0);
      apb(1'b1, ra(1, 12), 32'h0);
      rdc(ra(1, 4), 32'h3);
      rdc(ra(1, 8), 32'h1233);
      rdc(ra(1, 12), 32'h2007);
      xfer_req[0] <= 1'b1;
      wait_wr(1);
      chk(last_ra, 32'h1232);
      chk(last_wa, 32'h2004);
      rdc(ra(1, 4), 32'h2);
      wait_wr(3);
      repeat (60) @(posedge pclk);
      chk(32'(n_wr), 32'h3);
      rdc(ra(1, 4), 32'h0);
      apb(1'b1, ra(1, 0), 32'h0);
      apb(1'b1, ra(1, 4), 32'h1);
      apb(1'b1, ra(1, 0), cfg(1, 0, 1, 2));
      wait_wr(4);
      // A zero count never moves data, then each size code aligns as coded.
      rdel <= 4'h0;
      wdel <= 4'h0;
      xfer_req[1] <= 1'b1;
      apb(1'b1, ra(2, 0), cfg(1, 0, 0, 0));
      repeat (30) @(posedge pclk);
      chk(32'(n_wr), 32'h4);
      for (int s = 0; s < 3; s++) begin
         apb(1'b1, ra(2, 0), 32'h0);
         apb(1'b1, ra(2, 4), 32'h1);
         apb(1'b1, ra(2, 8), 32'h3003);
         apb(1'b1, ra(2, 12), 32'h4003);
         apb(1'b1, ra(2, 0), cfg(1, 0, s, 2 - s));
         wait_wr(5 + s);
         chk(last_ra, 32'h3003 & (32'hffff_ffff << s));
         chk(last_wa, 32'h4003 & (32'hffff_ffff << (2 - s)));
         chk(32'(rd_size), 32'(s));
         chk(32'(last_ws), 32'(2 - s));
      end
      // Memory to peripheral with no request line, by memory-to-memory mode.
      xfer_req[1] <= 1'b0;
      apb(1'b1, ra(2, 0), 32'h0);
      apb(1'b1, ra(2, 4), 32'h1);
      apb(1'b1, ra(2, 0), cfg(1, 0, 1, 2) | (32'h1 << `CFG_DIR_BIT) | (32'h1 << `CFG_M2M_BIT));
      wait_wr(8);
      chk(last_ra, 32'h4000);
      chk(last_wa, 32'h3002);
      // Auto-reload with a stalling writer, so the buffer fills.
      wdel <= 4'h8;
      b = n_wr;
      apb(1'b1, ra(3, 4), 32'h2);
      apb(1'b1, ra(3, 0), cfg(1, 1, 2, 2));
      xfer_req[2] <= 1'b1;
      wait_wr(b + 5);
      xfer_req[2] <= 1'b0;
      repeat (80) @(posedge pclk);
      rdc(ra(3, 4), ((n_wr - b) % 2 == 0) ? 32'h2 : 32'h1);
      end_sim;
   end
endmodule // tb_top
